// ---- hdl/timer16_lowpower_irq_ctrl.sv ----
// 16-bit capture/compare timer with halt handling, shared irq, AXI4-Lite
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module timer16_lowpower_irq_ctrl
    import timer16_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic halt_active,
    input wire logic global_irq_unmask,
    input wire logic capture_input_one,
    input wire logic capture_input_two,
    input wire logic ext_clk_in,
    output logic compare_pin_one,
    output logic compare_pin_one_oe,
    output logic compare_pin_two,
    output logic compare_pin_two_oe,
    output logic timer_irq
);

    function automatic logic edge_of(input logic cur, input logic prev,
                                     input logic rising);
        edge_of = rising ? (cur & ~prev) : (~cur & prev);
    endfunction

    function automatic logic [7:0] clr_mask(input logic [7:0] a);
        clr_mask = 8'h00;
        case (a)
            ADDR_CAP_ONE: clr_mask[ST_CAP_ONE] = 1'b1;
            ADDR_CMP_ONE: clr_mask[ST_CMP_ONE] = 1'b1;
            ADDR_COUNT: clr_mask[ST_OVF] = 1'b1;
            ADDR_CAP_TWO: clr_mask[ST_CAP_TWO] = 1'b1;
            ADDR_CMP_TWO: clr_mask[ST_CMP_TWO] = 1'b1;
            default: clr_mask = 8'h00;
        endcase
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= ADDR_W'(ADDR_ALT_COUNT));
    endfunction

    ctrl_one_t ctrl_one_q;
    ctrl_two_t ctrl_two_q;
    mode_t mode;
    logic [7:0] flags_q, snap_q, set_v, clr_v;
    logic [15:0] cnt_q, cap_one_q, cap_two_q, cmp_one_q, cmp_two_q;
    logic cmp_one_inhibit_q, cmp_two_inhibit_q;
    logic [2:0] presc_q;
    logic halt_prev_q, arm_one_q, arm_two_q;
    logic cap_one_prev_q, cap_two_prev_q, ext_prev_q;
    logic pin_one_q, pin_two_q;
    logic run, tick, ext_edge, edge_one, edge_two, halt_exit;
    logic match_one, match_two, pulse_trigger, overflow;
    logic cap_one_now, cap_two_now;
    logic aw_got_q, w_got_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_en, rd_en;
    logic [7:0] waddr8, raddr8;
    logic [31:0] rd_word;

    // ---------------- AXI4-Lite slave ----------------
    assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_en = aw_got_q & w_got_q & ~s_axi_bvalid;
    assign rd_en = s_axi_arvalid & s_axi_arready;
    assign waddr8 = 8'(awaddr_q);
    assign raddr8 = 8'(s_axi_araddr);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (raddr8)
            ADDR_CTRL_ONE: rd_word[7:0] = ctrl_one_q;
            ADDR_CTRL_TWO: rd_word[7:0] = ctrl_two_q;
            ADDR_STATUS: rd_word[7:0] = flags_q;
            ADDR_CAP_ONE: rd_word[15:0] = cap_one_q;
            ADDR_CAP_TWO: rd_word[15:0] = cap_two_q;
            ADDR_CMP_ONE: rd_word[15:0] = cmp_one_q;
            ADDR_CMP_TWO: rd_word[15:0] = cmp_two_q;
            ADDR_COUNT, ADDR_ALT_COUNT: rd_word[15:0] = cnt_q;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_en) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- Control and data registers ----------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_one_q <= ctrl_one_t'(CTRL_RESET);
            ctrl_two_q <= ctrl_two_t'(CTRL_RESET);
        end else if (wr_en && wstrb_q[0]) begin
            if (waddr8 == ADDR_CTRL_ONE)
                ctrl_one_q <= ctrl_one_t'(wdata_q[7:0]);
            if (waddr8 == ADDR_CTRL_TWO)
                ctrl_two_q <= ctrl_two_t'(wdata_q[7:0]);
        end
    end

    // A high-byte-only write holds off compares until the low byte lands,
    // so a half-updated value never matches.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_one_q <= CMP_RESET;
            cmp_two_q <= CMP_RESET;
            cmp_one_inhibit_q <= 1'b0;
            cmp_two_inhibit_q <= 1'b0;
        end else if (wr_en && waddr8 == ADDR_CMP_ONE) begin
            if (wstrb_q[1]) cmp_one_q[15:8] <= wdata_q[15:8];
            if (wstrb_q[0]) cmp_one_q[7:0] <= wdata_q[7:0];
            cmp_one_inhibit_q <= wstrb_q[1] & ~wstrb_q[0];
        end else if (wr_en && waddr8 == ADDR_CMP_TWO) begin
            if (wstrb_q[1]) cmp_two_q[15:8] <= wdata_q[15:8];
            if (wstrb_q[0]) cmp_two_q[7:0] <= wdata_q[7:0];
            cmp_two_inhibit_q <= wstrb_q[1] & ~wstrb_q[0];
        end
    end

    // ---------------- Mode, prescaler, edges ----------------
    always_comb begin
        if (ctrl_two_q.pwm_select) mode = MODE_PWM;
        else if (ctrl_two_q.one_pulse_select) mode = MODE_ONE_PULSE;
        else mode = MODE_NORMAL;
    end

    assign run = ~halt_active;
    assign ext_edge = edge_of(ext_clk_in, ext_prev_q,
                              ctrl_two_q.ext_clock_edge);

    always_comb begin
        case (ctrl_two_q.clock_select_field)
            CLK_DIV2: tick = run & presc_q[0];
            CLK_DIV4: tick = run & (&presc_q[1:0]);
            CLK_DIV8: tick = run & (&presc_q);
            default: tick = run & ext_edge;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) presc_q <= 3'b000;
        else if (run) presc_q <= presc_q + 3'b001;
    end

    // Edge history keeps tracking in halt so a capture edge can arm
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_one_prev_q <= 1'b0;
            cap_two_prev_q <= 1'b0;
            ext_prev_q <= 1'b0;
            halt_prev_q <= 1'b0;
        end else begin
            cap_one_prev_q <= capture_input_one;
            cap_two_prev_q <= capture_input_two;
            ext_prev_q <= ext_clk_in;
            halt_prev_q <= halt_active;
        end
    end

    assign edge_one = edge_of(capture_input_one, cap_one_prev_q,
                              ctrl_one_q.capture_edge_one);
    assign edge_two = edge_of(capture_input_two, cap_two_prev_q,
                              ctrl_two_q.capture_edge_two);
    assign halt_exit = halt_prev_q & ~halt_active;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arm_one_q <= 1'b0;
            arm_two_q <= 1'b0;
        end else begin
            if (halt_exit) arm_one_q <= 1'b0;
            else if (halt_active && edge_one && mode == MODE_NORMAL)
                arm_one_q <= 1'b1;
            if (halt_exit) arm_two_q <= 1'b0;
            else if (halt_active && edge_two) arm_two_q <= 1'b1;
        end
    end

    // ---------------- Counter, compares, captures ----------------
    assign match_one = tick & ~cmp_one_inhibit_q & (cnt_q == cmp_one_q);
    assign match_two = tick & ~cmp_two_inhibit_q & (cnt_q == cmp_two_q);
    assign pulse_trigger = run & edge_one & (mode == MODE_ONE_PULSE);
    assign overflow = tick & (cnt_q == CNT_MAX);
    assign cap_one_now = (run & edge_one & (mode == MODE_NORMAL)) |
                         (halt_exit & arm_one_q);
    assign cap_two_now = (run & edge_two) | (halt_exit & arm_two_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= CNT_RESET;
        end else if (wr_en && (waddr8 == ADDR_COUNT ||
                               waddr8 == ADDR_ALT_COUNT)) begin
            cnt_q <= CNT_RESET;
        end else if (pulse_trigger) begin
            cnt_q <= CNT_RESET;
        end else if (tick) begin
            if (mode == MODE_PWM && match_two) cnt_q <= CNT_RESET;
            else cnt_q <= cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_one_q <= CAP_RESET;
            cap_two_q <= CAP_RESET;
        end else begin
            if (pulse_trigger) cap_one_q <= CAP_PULSE_VALUE;
            else if (cap_one_now) cap_one_q <= cnt_q;
            if (cap_two_now) cap_two_q <= cnt_q;
        end
    end

    // ---------------- Flags ----------------
    always_comb begin
        set_v = 8'h00;
        set_v[ST_CAP_ONE] = cap_one_now | pulse_trigger |
                            (mode == MODE_PWM & match_two);
        set_v[ST_CAP_TWO] = cap_two_now;
        set_v[ST_CMP_ONE] = match_one & (mode == MODE_NORMAL);
        set_v[ST_CMP_TWO] = match_two & (mode != MODE_PWM);
        set_v[ST_OVF] = overflow & ~(mode == MODE_PWM & match_two);
    end

    // Clearing needs a status read first; only flags seen then are cleared
    assign clr_v = snap_q & ((rd_en ? clr_mask(raddr8) : 8'h00) |
                             (wr_en ? clr_mask(waddr8) : 8'h00));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= FLAGS_RESET;
            snap_q <= FLAGS_RESET;
        end else begin
            flags_q <= (flags_q & ~clr_v) | set_v;
            if (rd_en && raddr8 == ADDR_STATUS) snap_q <= flags_q;
            else snap_q <= snap_q & ~clr_v;
        end
    end

    assign timer_irq = global_irq_unmask & (
        (ctrl_one_q.capture_irq_enable &
         (flags_q[ST_CAP_ONE] | flags_q[ST_CAP_TWO])) |
        (ctrl_one_q.compare_irq_enable &
         (flags_q[ST_CMP_ONE] | flags_q[ST_CMP_TWO])) |
        (ctrl_one_q.overflow_irq_enable & flags_q[ST_OVF]));

    // ---------------- Compare pins ----------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_one_q <= 1'b0;
        end else if (run) begin
            case (mode)
                MODE_PWM: begin
                    if (match_two) pin_one_q <= ctrl_one_q.out_level_two;
                    else if (match_one) pin_one_q <= ctrl_one_q.out_level_one;
                end
                MODE_ONE_PULSE: begin
                    if (pulse_trigger) pin_one_q <= ctrl_one_q.out_level_two;
                    else if (match_one) pin_one_q <= ctrl_one_q.out_level_one;
                end
                default: begin
                    if (ctrl_one_q.force_out_one || match_one)
                        pin_one_q <= ctrl_one_q.out_level_one;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_two_q <= 1'b0;
        end else if (run && mode == MODE_NORMAL) begin
            if (ctrl_one_q.force_out_two || match_two)
                pin_two_q <= ctrl_one_q.out_level_two;
        end
    end

    // Enables only hand the pins over; compare logic above runs anyway
    assign compare_pin_one = pin_one_q;
    assign compare_pin_one_oe = ctrl_two_q.compare_pin_one_enable;
    assign compare_pin_two = pin_two_q;
    assign compare_pin_two_oe = ctrl_two_q.compare_pin_two_enable;

    // ---------------- Assertions ----------------
    property p_irq_masked;
        @(posedge clk) disable iff (!rst_n)
        !global_irq_unmask |-> !timer_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("irq raised while globally masked");

    property p_cap_irq;
        @(posedge clk) disable iff (!rst_n)
        global_irq_unmask && ctrl_one_q.capture_irq_enable &&
        flags_q[ST_CAP_TWO] |-> timer_irq;
    endproperty
    a_cap_irq: assert property (p_cap_irq)
        else $error("capture flag did not raise irq");

    property p_halt_freeze;
        @(posedge clk) disable iff (!rst_n)
        halt_active && !wr_en |=> cnt_q == $past(cnt_q);
    endproperty
    a_halt_freeze: assert property (p_halt_freeze)
        else $error("counter moved during halt");

    property p_halt_capture;
        @(posedge clk) disable iff (!rst_n)
        halt_exit && arm_two_q |=> flags_q[ST_CAP_TWO] &&
        cap_two_q == $past(cnt_q);
    endproperty
    a_halt_capture: assert property (p_halt_capture)
        else $error("armed capture not taken on halt exit");

    property p_pwm_no_cmp;
        @(posedge clk) disable iff (!rst_n)
        mode == MODE_PWM && $past(mode) == MODE_PWM |->
        !$rose(flags_q[ST_CMP_ONE]) && !$rose(flags_q[ST_CMP_TWO]);
    endproperty
    a_pwm_no_cmp: assert property (p_pwm_no_cmp)
        else $error("compare flag set in PWM mode");

    property p_pwm_cap_flag;
        @(posedge clk) disable iff (!rst_n)
        mode == MODE_PWM && match_two |=> flags_q[ST_CAP_ONE] &&
        cnt_q == CNT_RESET;
    endproperty
    a_pwm_cap_flag: assert property (p_pwm_cap_flag)
        else $error("PWM period end did not set capture flag one");

    property p_pwm_pin;
        @(posedge clk) disable iff (!rst_n)
        mode == MODE_PWM && match_two |=>
        compare_pin_one == $past(ctrl_one_q.out_level_two);
    endproperty
    a_pwm_pin: assert property (p_pwm_pin)
        else $error("PWM pin one did not take level two");

    property p_force_one;
        @(posedge clk) disable iff (!rst_n)
        run && mode == MODE_NORMAL && ctrl_one_q.force_out_one |=>
        compare_pin_one == $past(ctrl_one_q.out_level_one);
    endproperty
    a_force_one: assert property (p_force_one)
        else $error("forced level one not on pin one");

    property p_edge_capture;
        @(posedge clk) disable iff (!rst_n)
        run && mode == MODE_NORMAL && edge_one |=>
        flags_q[ST_CAP_ONE] && cap_one_q == $past(cnt_q);
    endproperty
    a_edge_capture: assert property (p_edge_capture)
        else $error("capture edge one not captured");

    property p_match_pin;
        @(posedge clk) disable iff (!rst_n)
        mode == MODE_NORMAL && match_one |=>
        compare_pin_one == $past(ctrl_one_q.out_level_one) &&
        flags_q[ST_CMP_ONE];
    endproperty
    a_match_pin: assert property (p_match_pin)
        else $error("compare one match did not update pin and flag");

    property p_div4;
        @(posedge clk) disable iff (!rst_n)
        tick && ctrl_two_q.clock_select_field == CLK_DIV4 &&
        !wr_en |=>
        (!tick || ctrl_two_q.clock_select_field != CLK_DIV4) [*3];
    endproperty
    a_div4: assert property (p_div4)
        else $error("divide by 4 ticked early");

    property p_ovf_flag;
        @(posedge clk) disable iff (!rst_n)
        overflow && mode == MODE_NORMAL |=> flags_q[ST_OVF];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag)
        else $error("overflow did not set its flag");

    c_halt_wake: cover property (@(posedge clk) disable iff (!rst_n)
        halt_exit && arm_one_q);
    c_pwm_period: cover property (@(posedge clk) disable iff (!rst_n)
        mode == MODE_PWM && match_two);
    c_pulse: cover property (@(posedge clk) disable iff (!rst_n)
        pulse_trigger ##[1:100] match_one);
    c_irq: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(timer_irq));

endmodule
`default_nettype wire

// ---- hdl/timer16_pkg.sv ----
// Shared constants and types for the 16-bit capture/compare timer
package timer16_pkg;

    // Register byte offsets on the AXI4-Lite port
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CAP_ONE = 8'h0c;
    localparam logic [7:0] ADDR_CAP_TWO = 8'h10;
    localparam logic [7:0] ADDR_CMP_ONE = 8'h14;
    localparam logic [7:0] ADDR_CMP_TWO = 8'h18;
    localparam logic [7:0] ADDR_COUNT = 8'h1c;
    localparam logic [7:0] ADDR_ALT_COUNT = 8'h20;

    // Status bit positions
    localparam int ST_CAP_ONE = 7;
    localparam int ST_CMP_ONE = 6;
    localparam int ST_OVF = 5;
    localparam int ST_CAP_TWO = 4;
    localparam int ST_CMP_TWO = 3;

    // Reset and load values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'hfffc;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CAP_PULSE_VALUE = 16'hfffd;
    localparam logic [15:0] CMP_RESET = 16'h8000;
    localparam logic [15:0] CAP_RESET = 16'h0000;

    // Counter clock selection
    localparam logic [1:0] CLK_DIV4 = 2'b00;
    localparam logic [1:0] CLK_DIV2 = 2'b01;
    localparam logic [1:0] CLK_DIV8 = 2'b10;
    localparam logic [1:0] CLK_EXT = 2'b11;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic capture_irq_enable;
        logic compare_irq_enable;
        logic overflow_irq_enable;
        logic force_out_two;
        logic force_out_one;
        logic out_level_two;
        logic capture_edge_one;
        logic out_level_one;
    } ctrl_one_t;

    typedef struct packed {
        logic compare_pin_one_enable;
        logic compare_pin_two_enable;
        logic one_pulse_select;
        logic pwm_select;
        logic [1:0] clock_select_field;
        logic capture_edge_two;
        logic ext_clock_edge;
    } ctrl_two_t;

    typedef enum {MODE_NORMAL, MODE_ONE_PULSE, MODE_PWM} mode_t;

endpackage

// ---- tb/cpu_pin_model.sv ----
// CPU-side partner: halt, unmask, wait state and capture pins
`timescale 1ns/100ps
`default_nettype none
module cpu_pin_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic timer_irq,
    input wire logic halt_req,
    input wire logic unmask_req,
    input wire logic [1:0] cap_req,
    output logic halt_active,
    output logic global_irq_unmask,
    output logic capture_input_one,
    output logic capture_input_two,
    output logic ext_clk_in,
    output logic waiting
);
    // Pins change only on clock edges, as the timer samples them there
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_active <= 1'b0;
            global_irq_unmask <= 1'b0;
            {capture_input_two, capture_input_one} <= 2'b01;
            ext_clk_in <= 1'b0;
        end else begin
            halt_active <= halt_req;
            global_irq_unmask <= unmask_req;
            {capture_input_two, capture_input_one} <= cap_req;
            ext_clk_in <= ~ext_clk_in;
        end
    end
    // Core sleeps in wait after reset; any timer request wakes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) waiting <= 1'b1;
        else if (timer_irq) waiting <= 1'b0;
    end
endmodule
`default_nettype wire

// ---- tb/test_timer16_lowpower_irq_ctrl.sv ----
// Self-checking bench for the capture/compare timer
`timescale 1ns/100ps
`default_nettype none
module test_timer16_lowpower_irq_ctrl;
    import timer16_pkg::*;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, bv, br = 0, arv = 0, rv, rr = 0;
    logic awr, wr, arr, p1, o1, p2, o2, irq, halt, unm, hq = 0, uq = 0, wt;
    logic [7:0] aw = 0, ar = 0;
    logic [31:0] wd = 0, rd, v, c;
    logic [1:0] bresp, rresp, cq = 2'b01, r;
    logic c1, c2, ek;
    int n_errors = 0, checks_done = 0, cyc = 0;
    logic [7:0] ra [5] = '{ADDR_CTRL_ONE, ADDR_CTRL_TWO, ADDR_CMP_ONE,
        ADDR_CTRL_ONE, ADDR_CTRL_TWO};
    logic [31:0] rw [5] = '{32'ha5, 32'h3c, 32'h1234, 32'h0, 32'h0};
    timer16_lowpower_irq_ctrl i_dut (.clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .halt_active(halt),
        .global_irq_unmask(unm), .capture_input_one(c1),
        .capture_input_two(c2), .ext_clk_in(ek), .compare_pin_one(p1),
        .compare_pin_one_oe(o1), .compare_pin_two(p2),
        .compare_pin_two_oe(o2), .timer_irq(irq));
    cpu_pin_model i_cpu (.clk(clk), .rst_n(rst_n), .timer_irq(irq),
        .halt_req(hq), .unmask_req(uq), .cap_req(cq), .halt_active(halt),
        .global_irq_unmask(unm), .capture_input_one(c1),
        .capture_input_two(c2), .ext_clk_in(ek), .waiting(wt));
    initial forever #5 clk = ~clk;
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask
    // Both channels offered together; each dropped once its ready is seen
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        aw <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
        do begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
        end while (!(bv && br));
        r = bresp;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        ar <= a; arv <= 1; rr <= 1;
        do begin
            @(posedge clk);
            if (arr) arv <= 0;
        end while (!(rv && rr));
        v = rd;
        r = rresp;
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    initial begin
        wait_cyc(10);
        rst_n <= 1;
        wait_cyc(1);
        rd_reg(ADDR_CTRL_ONE);
        chk("ctrl1 reset", v, 32'h0);
        rd_reg(ADDR_CTRL_TWO);
        chk("ctrl2 reset", v, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr_reg(ra[i], rw[i]);
            rd_reg(ra[i]);
            chk("reg rw", v, rw[i]);
        end
        rd_reg(8'h40);
        chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
        wr_reg(ADDR_CTRL_TWO, 32'hc0);
        wr_reg(ADDR_CTRL_ONE, 32'h1d);
        wait_cyc(3);
        chk("forced pins", {p1, o1, p2, o2}, 4'hf);
        wr_reg(ADDR_CTRL_ONE, 32'h18);
        wait_cyc(3);
        chk("forced low", {p1, p2}, 2'b00);
        wr_reg(ADDR_CTRL_TWO, 32'h0);
        wr_reg(ADDR_CTRL_ONE, 32'h82);
        cq <= 2'b00;
        wait_cyc(5);
        rd_reg(ADDR_STATUS);
        chk("no fall capture", v & 32'h80, 32'h0);
        cq <= 2'b01;
        wait_cyc(5);
        chk("irq masked", {31'h0, irq}, 32'h0);
        uq <= 1;
        wait_cyc(3);
        chk("cap irq", {31'h0, irq}, 32'h1);
        chk("wait exit", {31'h0, wt}, 32'h0);
        wr_reg(ADDR_CTRL_ONE, 32'h02);
        wait_cyc(2);
        chk("cap irq off", {31'h0, irq}, 32'h0);
        rd_reg(ADDR_STATUS);
        rd_reg(ADDR_CAP_ONE);
        rd_reg(ADDR_STATUS);
        chk("flag cleared", v & 32'h80, 32'h0);
        hq <= 1;
        wait_cyc(3);
        rd_reg(ADDR_COUNT);
        c = v;
        // Falling edge on capture two while halted arms it
        cq <= 2'b11;
        wait_cyc(10);
        cq <= 2'b01;
        wait_cyc(10);
        rd_reg(ADDR_COUNT);
        chk("halt frozen", v, c);
        hq <= 0;
        wait_cyc(20);
        rd_reg(ADDR_COUNT);
        chk("resumed", {31'h0, v !== c}, 32'h1);
        rd_reg(ADDR_CAP_TWO);
        chk("halt capture", v, c);
        rd_reg(ADDR_STATUS);
        chk("halt cap flag", v & 32'h10, 32'h10);
        // Wake by reset: counter restarts from its reset value
        rst_n <= 0;
        wait_cyc(3);
        rst_n <= 1;
        rd_reg(ADDR_COUNT);
        chk("reset restart", v, {16'h0, CNT_RESET});
        rd_reg(ADDR_CTRL_ONE);
        chk("ctrl1 re-reset", v, 32'h0);
        wr_reg(ADDR_CTRL_TWO, 32'h80);
        wr_reg(ADDR_CTRL_ONE, 32'h41);
        wr_reg(ADDR_CMP_ONE, 32'h0002);
        wr_reg(ADDR_COUNT, 32'h0);
        wait_cyc(40);
        rd_reg(ADDR_STATUS);
        chk("cmp1 flag", v & 32'h40, 32'h40);
        chk("cmp1 pin", {p1, o1}, 2'b11);
        chk("cmp irq", {31'h0, irq}, 32'h1);
        rd_reg(ADDR_CMP_ONE);
        // Both mode bits set: period end must behave as PWM only
        wr_reg(ADDR_CTRL_ONE, 32'h84);
        wr_reg(ADDR_CMP_TWO, 32'h0002);
        wr_reg(ADDR_CTRL_TWO, 32'hb0);
        wr_reg(ADDR_COUNT, 32'h0);
        wait_cyc(60);
        rd_reg(ADDR_STATUS);
        chk("pwm flags", v & 32'hc8, 32'h80);
        chk("pwm irq", {31'h0, irq}, 32'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
